// >>> sac_pkg.sv
// Shared constants, types and helpers for the converter conversion control
package sac_pkg;

  localparam int SAC_BITS = 8;
  localparam int SAC_IN_W = 16;
  localparam logic [7:0] SAC_TRIAL_INIT = 8'h80;
  localparam logic [2:0] SAC_IDX_INIT = 3'h7;
  localparam logic [7:0] SAC_LATCH_RST = 8'h00;
  localparam logic [7:0] SAC_CODE_MIN = 8'h00;
  localparam logic [7:0] SAC_CODE_MAX = 8'hFF;
  localparam logic [7:0] SAC_LSB_ZERO = 8'h00;
  localparam logic [1:0] SAC_STEP_LAST = 2'h3;
  localparam logic [1:0] SAC_STEP_ZERO = 2'h0;

  typedef enum logic [1:0] {
    SAC_IDLE = 2'h1,
    SAC_CONV = 2'h2
  } sac_mode_t;

  typedef struct packed {
    sac_mode_t st;
    logic [7:0] trial;
    logic [2:0] idx;
    logic [1:0] cnt;
    logic [7:0] latch;
    logic done_n;
    logic arm;
    logic oe;
  } sac_state_t;

  // Signed difference of the two inputs; the span is 2^16 units, one code step is 256 units
  function automatic logic [16:0] sac_diff(input logic [15:0] pos, input logic [15:0] neg);
    sac_diff = {1'h0, pos} - {1'h0, neg};
  endfunction : sac_diff

  // Ideal straight binary code of the input difference
  function automatic logic [7:0] sac_ideal(input logic [15:0] pos, input logic [15:0] neg);
    logic [16:0] d;
    d = sac_diff(pos, neg);
    sac_ideal = d[16] ? SAC_CODE_MIN : d[15:8];
  endfunction : sac_ideal

endpackage : sac_pkg

// >>> sac_cmp.sv
// Trial comparator of the successive approximation loop
`timescale 1ns/10ps
module sac_cmp
  import sac_pkg::*;
(
  input wire logic [15:0] analog_in_pos,
  input wire logic [15:0] analog_in_neg,
  input wire logic [7:0] trial,
  output logic keep
);

  logic [16:0] d;

  // Negative differences clamp to the bottom code
  always_comb begin
    d = sac_diff(analog_in_pos, analog_in_neg);
    keep = !d[16] && (d[15:0] >= {trial, SAC_LSB_ZERO});
  end

endmodule : sac_cmp

// >>> sac_ctrl.sv
// Conversion control: start strobe, restart, result latch and completion flag
`timescale 1ns/10ps
module sac_ctrl
  import sac_pkg::*;
(
  input wire logic clock,
  input wire logic rst,
  input wire logic chip_sel_n,
  input wire logic mem_write_strobe_n,
  input wire logic mem_read_strobe_n,
  input wire logic [15:0] analog_in_pos,
  input wire logic [15:0] analog_in_neg,
  output logic [7:0] data_out,
  output logic data_oe,
  output logic conv_done_n
);

  sac_state_t s_r;
  sac_state_t s_nxt;
  logic keep;
  logic start_pls;
  logic wr_low;
  logic rd_acc;
  logic step_end;
  logic finish;
  logic [7:0] result;

  // Lower bit index; never called on bit zero, so the wrap at zero is harmless
  function automatic logic [2:0] next_idx(input logic [2:0] i);
    next_idx = i - 3'h1;
  endfunction : next_idx

  sac_cmp u_cmp (
    .analog_in_pos(analog_in_pos),
    .analog_in_neg(analog_in_neg),
    .trial(s_r.trial),
    .keep(keep)
  );

  assign wr_low = !chip_sel_n && !mem_write_strobe_n;
  assign rd_acc = !chip_sel_n && !mem_read_strobe_n;
  // Start fires on the release after a low select and strobe were seen together
  assign start_pls = s_r.arm && mem_write_strobe_n;
  assign step_end = (s_r.st == SAC_CONV) && (s_r.cnt == SAC_STEP_LAST);
  assign finish = step_end && (s_r.idx == 3'h0) && !start_pls;

  // Bit under trial resolved by the comparator
  always_comb begin
    result = s_r.trial;
    result[s_r.idx] = keep;
  end

  always_comb begin
    s_nxt = s_r;
    s_nxt.arm = wr_low;
    s_nxt.oe = rd_acc;
    // Flag clears on a read or on the falling strobe, which lets the free-running loop re-arm itself
    if (rd_acc || wr_low) begin
      s_nxt.done_n = 1'h1;
    end
    unique case (s_r.st)
      SAC_IDLE: begin
        s_nxt.cnt = SAC_STEP_ZERO;
      end
      SAC_CONV: begin
        s_nxt.cnt = s_r.cnt + 2'h1;
        s_nxt.done_n = 1'h1;
        if (step_end) begin
          if (s_r.idx == 3'h0) begin
            s_nxt.latch = result;
            s_nxt.done_n = 1'h0;
            s_nxt.st = SAC_IDLE;
          end else begin
            s_nxt.trial = result;
            s_nxt.trial[next_idx(s_r.idx)] = 1'h1;
            s_nxt.idx = next_idx(s_r.idx);
          end
        end
      end
      default: begin
        s_nxt.st = SAC_IDLE;
      end
    endcase
    // Start wins over completion: a partial result is dropped and the old latch stays
    if (start_pls) begin
      s_nxt.st = SAC_CONV;
      s_nxt.trial = SAC_TRIAL_INIT;
      s_nxt.idx = SAC_IDX_INIT;
      s_nxt.cnt = SAC_STEP_ZERO;
      s_nxt.latch = s_r.latch;
      s_nxt.done_n = 1'h1;
    end
  end

  always_ff @(posedge clock) begin
    if (rst) begin
      s_r <= '{st: SAC_IDLE, trial: SAC_TRIAL_INIT, idx: SAC_IDX_INIT, cnt: SAC_STEP_ZERO,
               latch: SAC_LATCH_RST, done_n: 1'h1, arm: 1'h0, oe: 1'h0};
    end else begin
      s_r <= s_nxt;
    end
  end

  assign data_out = s_r.latch;
  assign data_oe = s_r.oe;
  assign conv_done_n = s_r.done_n;

  // Checks

  restart_seq_a: assert property (@(posedge clock) disable iff (rst)
    start_pls && (s_r.st == SAC_CONV) |=> (s_r.st == SAC_CONV) && (s_r.trial == SAC_TRIAL_INIT)
      && (s_r.idx == SAC_IDX_INIT) && (s_r.cnt == SAC_STEP_ZERO))
    else $error("restart did not reset the sequencer");

  latch_hold_a: assert property (@(posedge clock) disable iff (rst)
    !finish |=> $stable(data_out))
    else $error("latch changed without a completed conversion");

  restart_flag_a: assert property (@(posedge clock) disable iff (rst)
    start_pls |=> conv_done_n [*8])
    else $error("completion flag dropped after restart");

  code_value_a: assert property (@(posedge clock) disable iff (rst)
    finish && $stable(analog_in_pos) && $stable(analog_in_neg) && $past(s_r.st == SAC_CONV, 31)
      |=> data_out == $past(sac_ideal(analog_in_pos, analog_in_neg)))
    else $error("converted code differs from ideal code");

  code_floor_a: assert property (@(posedge clock) disable iff (rst)
    finish && (analog_in_pos <= analog_in_neg) |=> data_out == SAC_CODE_MIN)
    else $error("negative or zero input did not give bottom code");

  start_conv_a: assert property (@(posedge clock) disable iff (rst)
    (s_r.st == SAC_CONV) |-> conv_done_n)
    else $error("completion flag low during conversion");

  start_go_a: assert property (@(posedge clock) disable iff (rst)
    $past(wr_low) && mem_write_strobe_n |=> (s_r.st == SAC_CONV))
    else $error("strobe release did not start a conversion");

  done_flag_a: assert property (@(posedge clock) disable iff (rst)
    finish |=> !conv_done_n && (s_r.st == SAC_IDLE))
    else $error("completion did not drive the flag low");

  read_clear_a: assert property (@(posedge clock) disable iff (rst)
    rd_acc && !finish && !start_pls |=> conv_done_n && data_oe)
    else $error("read did not clear the flag or drive the bus");

  // Reset state, bit sequence and flag lifetime

  reset_state_a: assert property (@(posedge clock)
    rst |=> (data_out == SAC_LATCH_RST) && !data_oe && conv_done_n
      && (s_r.st == SAC_IDLE))
    else $error("reset did not return the outputs to idle");

  start_fresh_a: assert property (@(posedge clock) disable iff (rst)
    start_pls |=> (s_r.st == SAC_CONV) && (s_r.trial == SAC_TRIAL_INIT)
      && (s_r.idx == SAC_IDX_INIT) && conv_done_n)
    else $error("start did not launch a fresh conversion");

  abort_keep_a: assert property (@(posedge clock) disable iff (rst)
    start_pls && (s_r.st == SAC_CONV) |=> $stable(data_out))
    else $error("restart changed the output latch");

  abort_flag_a: assert property (@(posedge clock) disable iff (rst)
    start_pls && (s_r.st == SAC_CONV) |=> conv_done_n && (s_r.st == SAC_CONV))
    else $error("restart let the completion flag drop");

  step_order_a: assert property (@(posedge clock) disable iff (rst)
    step_end && (s_r.idx != 3'h0) && !start_pls
      |=> (s_r.st == SAC_CONV) && (s_r.idx == next_idx($past(s_r.idx))) && (s_r.cnt == SAC_STEP_ZERO))
    else $error("bit sequence skipped or repeated a step");

  trial_bit_a: assert property (@(posedge clock) disable iff (rst)
    (s_r.st == SAC_CONV) |-> s_r.trial[s_r.idx]
      && ((s_r.trial & ((8'h01 << s_r.idx) - 8'h01)) == SAC_CODE_MIN))
    else $error("trial code does not probe the current bit");

  latch_load_a: assert property (@(posedge clock) disable iff (rst)
    finish |=> data_out == $past(result))
    else $error("completion did not load the resolved code");

  code_top_a: assert property (@(posedge clock) disable iff (rst)
    finish && (sac_ideal(analog_in_pos, analog_in_neg) == SAC_CODE_MAX) |=> data_out == SAC_CODE_MAX)
    else $error("full-scale input did not give the top code");

  done_stand_a: assert property (@(posedge clock) disable iff (rst)
    !conv_done_n && !rd_acc && !wr_low && !start_pls |=> !conv_done_n && $stable(data_out))
    else $error("completion flag or latch changed without an access");

  write_clear_a: assert property (@(posedge clock) disable iff (rst)
    wr_low && !finish |=> conv_done_n && s_r.arm)
    else $error("select and strobe low did not clear the flag");

  oe_follow_a: assert property (@(posedge clock) disable iff (rst)
    !rd_acc |=> !data_oe)
    else $error("data bus driven without a read access");

  idle_stay_a: assert property (@(posedge clock) disable iff (rst)
    (s_r.st == SAC_IDLE) && !start_pls |=> (s_r.st == SAC_IDLE))
    else $error("conversion began without a start");

  restart_c: cover property (@(posedge clock) disable iff (rst) start_pls && (s_r.st == SAC_CONV));
  finish_c: cover property (@(posedge clock) disable iff (rst) finish ##1 !conv_done_n);
  read_c: cover property (@(posedge clock) disable iff (rst) !conv_done_n ##1 rd_acc);
  full_code_c: cover property (@(posedge clock) disable iff (rst) finish && (result == SAC_CODE_MAX));
  free_run_c: cover property (@(posedge clock) disable iff (rst)
    !conv_done_n && wr_low ##1 start_pls);

endmodule : sac_ctrl

// >>> sac_host.sv
// Host model: select, write and read strobes toward the converter
`timescale 1ns/10ps
module sac_host (
  input wire logic clock,
  input wire logic conv_done_n,
  input wire logic free,
  input wire logic kick,
  output logic chip_sel_n,
  output logic mem_write_strobe_n,
  output logic mem_read_strobe_n
);
  logic cs_r = 1'h1;
  logic wr_r = 1'h1;
  logic rd_r = 1'h1;
  assign chip_sel_n = free ? 1'h0 : cs_r;
  assign mem_write_strobe_n = free ? (conv_done_n & ~kick) : wr_r;
  assign mem_read_strobe_n = rd_r;
  // Strobes held two cycles, as a stretched access on a loaded bus
  task automatic strobe(input logic rd);
    @(negedge clock);
    cs_r = 1'h0;
    if (rd) rd_r = 1'h0;
    else wr_r = 1'h0;
    repeat (2) @(negedge clock);
    {cs_r, wr_r, rd_r} = 3'h7;
  endtask : strobe
endmodule : sac_host

// >>> sac_ctrl_tb.sv
// Self-checking bench for the conversion control
`timescale 1ns/10ps
module sac_ctrl_tb;
  import sac_pkg::*;
  logic clock = 1'h0;
  logic rst = 1'h1;
  logic free = 1'h0;
  logic kick = 1'h0;
  logic [15:0] pos = 16'h0000;
  logic [15:0] neg = 16'h0000;
  logic [15:0] lfsr = 16'h0031;
  logic chip_sel_n, mem_write_strobe_n, mem_read_strobe_n, data_oe, conv_done_n, done_q;
  logic [7:0] data_out, last;
  logic [7:0] notes[$];
  int num_errors = 0;
  int comparisons = 0;
  int n;
  initial forever #10 clock = ~clock;
  sac_host HOST (.clock(clock), .conv_done_n(conv_done_n), .free(free), .kick(kick), .chip_sel_n(chip_sel_n),
    .mem_write_strobe_n(mem_write_strobe_n), .mem_read_strobe_n(mem_read_strobe_n));
  sac_ctrl DUT (.clock(clock), .rst(rst), .chip_sel_n(chip_sel_n), .mem_write_strobe_n(mem_write_strobe_n),
    .mem_read_strobe_n(mem_read_strobe_n), .analog_in_pos(pos), .analog_in_neg(neg), .data_out(data_out),
    .data_oe(data_oe), .conv_done_n(conv_done_n));
  function automatic logic [15:0] next_rand(input logic [15:0] v);
    next_rand = {v[14:0], v[15] ^ v[13] ^ v[12] ^ v[10]};
  endfunction : next_rand
  task automatic tally_and_finish();
    $display("errors %0d comparisons %0d", num_errors, comparisons);
    if (num_errors == 0 && comparisons > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask : tally_and_finish
  task automatic check_code(input logic [7:0] got, input logic [7:0] exp, input string what);
    comparisons++;
    if (got !== exp) begin
      num_errors++;
      $display("BAD %0t %s", $time, what);
    end
  endtask : check_code
  task automatic check_flag(input logic got, input logic exp, input string what);
    check_code({7'h00, got}, {7'h00, exp}, what);
  endtask : check_flag
  task automatic load(input logic [15:0] p, input logic [15:0] q);
    pos = p;
    neg = q;
    notes.push_back(p >= q ? 8'((p - q) >> 8) : 8'h00);
  endtask : load
  // Bounded wait for the completion flag to reach a level
  task automatic wait_lvl(input logic v, output int t);
    t = 0;
    while (conv_done_n !== v) begin
      @(negedge clock);
      t++;
      if (t > 80) begin
        check_flag(1'h0, 1'h1, "timeout");
        tally_and_finish();
      end
    end
  endtask : wait_lvl
  // Each completion edge is matched against the oldest expected code
  always @(negedge clock) begin
    done_q <= conv_done_n;
    if (done_q === 1'h1 && conv_done_n === 1'h0) begin
      if (notes.size() == 0) check_flag(1'h0, 1'h1, "stray completion");
      else check_code(data_out, notes.pop_front(), "code");
    end
  end
  initial begin
    repeat (12) @(negedge clock);
    rst = 1'h0;
    for (int i = 0; i < 16; i++) begin
      lfsr = next_rand(lfsr);
      @(negedge clock);
      if (i == 0) load(16'hFFFF, 16'h0000);
      else if (i == 1) load(16'h0100, 16'h0200);
      else if (i == 2) load(16'hFEFF, 16'h0000);
      else load(lfsr, next_rand(lfsr));
      last = notes[$];
      HOST.strobe(1'h0);
      wait_lvl(1'h0, n);
      check_flag(n == 33, 1'h1, "latency");
      HOST.strobe(1'h1);
      check_flag(data_oe, 1'h1, "no drive");
      check_flag(conv_done_n, 1'h1, "flag kept");
    end
    load(16'h1234, 16'h0000);
    HOST.strobe(1'h0);
    repeat (10) @(negedge clock);
    void'(notes.pop_back());
    load(16'h8000, 16'h0100);
    HOST.strobe(1'h0);
    repeat (25) @(negedge clock);
    check_code(data_out, last, "latch");
    check_flag(conv_done_n, 1'h1, "flag");
    wait_lvl(1'h0, n);
    check_flag(n == 8, 1'h1, "restart");
    load(16'h4000, 16'h0000);
    notes.push_back(notes[$]);
    free = 1'h1;
    kick = 1'h1;
    @(negedge clock);
    kick = 1'h0;
    wait_lvl(1'h1, n);
    wait_lvl(1'h0, n);
    wait_lvl(1'h1, n);
    wait_lvl(1'h0, n);
    free = 1'h0;
    @(negedge clock);
    check_flag(notes.size() == 0, 1'h1, "free run");
    tally_and_finish();
  end
endmodule : sac_ctrl_tb
